// ---- logic/frt_regs.svh ----
// Functional notes
// - counter ticks on cpu clock divided by 2, 4 or 8, or external edge
// - write to either counter low byte reloads count with FFFC
// - reset count is FFFC, the only reload value in all modes
// - main and alternate counts read alike; alternate low never clears overflow
// - high byte read first buffers low byte until low byte is read
// - lone low byte read after a completed pair returns live low byte
// - wrap from FFFF to 0000 sets overflow flag
// - overflow request needs enable and cpu unmask, else stays pending
// - overflow flag clears on status read then main low byte access
// - counter runs in wait, stops in halt, resumes held count
// - both clock select bits one picks external clock with edge select
// - capture edge copies count into capture value and sets capture flag
// - each capture input has its own edge select bit
// - one shared capture enable; request pending until enabled and unmasked
// - capture flag clears on status read then capture low byte access
// - capture high byte read blocks capture until low byte read
// - capture value always holds the most recent capture
// - in one-pulse or pwm mode only capture two works normally
// - capture two input always connected, capture one only outside one-pulse and pwm mode; outputs not fed back
// - each tick compares both compare values, match sets flag; request needs enable and cpu unmask
// - compare values software only, reset to 8000
// - match with output enabled drives level bit to pin; pin low in reset
// - compare high byte write suspends compare until low byte written
`ifndef FRT_REGS_SVH
`define FRT_REGS_SVH
`define FRT_CTL1      4'h0
`define FRT_CTL2      4'h1
`define FRT_STATUS    4'h2
`define FRT_CAP1_HI   4'h3
`define FRT_CAP1_LO   4'h4
`define FRT_CMP1_HI   4'h5
`define FRT_CMP1_LO   4'h6
`define FRT_CNT_HI    4'h7
`define FRT_CNT_LO    4'h8
`define FRT_ACNT_HI   4'h9
`define FRT_ACNT_LO   4'hA
`define FRT_CAP2_HI   4'hB
`define FRT_CAP2_LO   4'hC
`define FRT_CMP2_HI   4'hD
`define FRT_CMP2_LO   4'hE
// control one bits
`define C1_CAP_IE     7
`define C1_CMP_IE     6
`define C1_OVF_IE     5
`define C1_LVL2       2
`define C1_EDGE1      1
`define C1_LVL1       0
// control two bits
`define C2_OUT1_EN    7
`define C2_OUT2_EN    6
`define C2_OPM        5
`define C2_PWM        4
`define C2_CS_HI      3
`define C2_CS_LO      2
`define C2_EDGE2      1
`define C2_EXT_EDGE   0
// status bits
`define ST_CAP1       7
`define ST_CMP1       6
`define ST_OVF        5
`define ST_CAP2       4
`define ST_CMP2       3
`define CNT_RESET     16'hFFFC
`define CMP_RESET     16'h8000
`define EXT_MIN_GAP   4
`endif

// ---- logic/frt_pkg.sv ----
package frt_pkg;
  typedef logic [3:0] reg_addr_t;
  typedef logic [7:0] byte_t;
  typedef enum logic [1:0] {
    CS_DIV4 = 2'b00,
    CS_DIV2 = 2'b01,
    CS_DIV8 = 2'b10,
    CS_EXT  = 2'b11
  } clk_sel_t;
endpackage : frt_pkg

// ---- logic/frt_timer.sv ----
// The implementer's own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "frt_regs.svh"
module frt_timer (
  // clock and reset
  input  wire logic            I_CLK,
  input  wire logic            I_RST,
  // register port
  input  wire frt_pkg::reg_addr_t I_ADDR,
  input  wire frt_pkg::byte_t  I_WDATA,
  input  wire logic            I_WR,
  input  wire logic            I_RD,
  output logic [7:0]           O_RDATA,
  // cpu state
  input  wire logic            I_CPU_UNMASK,
  input  wire logic            I_HALT,
  // pins
  input  wire logic            I_EXT_CLOCK_PIN,
  input  wire logic            I_CAPTURE_INPUT_ONE,
  input  wire logic            I_CAPTURE_INPUT_TWO,
  output logic                 O_COMPARE_OUTPUT_PIN1,
  output logic                 O_COMPARE_OUTPUT_PIN2,
  output logic                 O_COMPARE_OE1,
  output logic                 O_COMPARE_OE2,
  // interrupt requests
  output logic                 O_OVF_IRQ,
  output logic                 O_CAP_IRQ,
  output logic                 O_CMP_IRQ
);
  import frt_pkg::*;

  logic [7:0]  ctl1_ff;
  logic [7:0]  ctl2_ff;
  logic [15:0] count_ff;
  logic [2:0]  presc_ff;
  logic [2:0]  ext_sync_ff;
  logic [2:0]  cap_sync1_ff;
  logic [2:0]  cap_sync2_ff;
  logic        overflow_flag_ff;
  logic [1:0]  capture_flag_ff;
  logic [1:0]  compare_flag_ff;
  logic [15:0] capture_value_ff [2];
  logic [15:0] compare_value_ff [2];
  logic [1:0]  cap_block_ff;
  logic [1:0]  cmp_hold_ff;
  logic [7:0]  low_buf_ff;
  logic        low_buf_vld_ff;
  logic [1:0]  cap_armed_ff;
  logic [1:0]  cmp_armed_ff;
  logic        ovf_armed_ff;
  logic [7:0]  rdata_ff;
  logic [1:0]  pin_ff;
  logic [1:0]  oe_ff;
  logic        ovf_irq_ff;
  logic        cap_irq_ff;
  logic        cmp_irq_ff;

  clk_sel_t    clk_sel;
  logic        tick;
  logic        ext_edge;
  logic        cnt_lo_wr;
  logic        pulse_mode;
  logic [15:0] nxt_count;
  logic [1:0]  cap_edge;
  logic [1:0]  cap_edge_sel;
  logic [1:0]  cap_active;
  logic [1:0]  cmp_match;
  logic        st_rd;

  assign clk_sel      = clk_sel_t'(ctl2_ff[`C2_CS_HI:`C2_CS_LO]);
  assign pulse_mode   = ctl2_ff[`C2_OPM] | ctl2_ff[`C2_PWM];
  assign st_rd        = I_RD && (I_ADDR == `FRT_STATUS);
  assign cnt_lo_wr    = I_WR && (I_ADDR == `FRT_CNT_LO || I_ADDR == `FRT_ACNT_LO);
  assign cap_edge_sel = {ctl2_ff[`C2_EDGE2], ctl1_ff[`C1_EDGE1]};
  assign cap_active   = {1'b1, ~pulse_mode};

  // pin synchronisers: bit0 first stage, bit1 second, bit2 history
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ext_sync_ff  <= 3'h0;
      cap_sync1_ff <= 3'h0;
      cap_sync2_ff <= 3'h0;
    end else begin
      ext_sync_ff  <= {ext_sync_ff[1:0], I_EXT_CLOCK_PIN};
      cap_sync1_ff <= {cap_sync1_ff[1:0], I_CAPTURE_INPUT_ONE};
      cap_sync2_ff <= {cap_sync2_ff[1:0], I_CAPTURE_INPUT_TWO};
    end
  end

  // external active edge; rising when edge select is one
  assign ext_edge = ctl2_ff[`C2_EXT_EDGE] ? (ext_sync_ff[1] & ~ext_sync_ff[2])
                                          : (~ext_sync_ff[1] & ext_sync_ff[2]);
  assign cap_edge[0] = cap_edge_sel[0] ? (cap_sync1_ff[1] & ~cap_sync1_ff[2])
                                       : (~cap_sync1_ff[1] & cap_sync1_ff[2]);
  assign cap_edge[1] = cap_edge_sel[1] ? (cap_sync2_ff[1] & ~cap_sync2_ff[2])
                                       : (~cap_sync2_ff[1] & cap_sync2_ff[2]);

  // prescaler
  always_ff @(posedge I_CLK) begin
    if (I_RST || cnt_lo_wr) begin
      presc_ff <= 3'h0;
    end else if (!I_HALT) begin
      presc_ff <= presc_ff + 3'h1;
    end
  end

  always_comb begin
    case (clk_sel)
      CS_DIV2: tick = presc_ff[0];
      CS_DIV4: tick = (presc_ff[1:0] == 2'h3);
      CS_DIV8: tick = (presc_ff == 3'h7);
      CS_EXT:  tick = ext_edge;
      default: tick = 1'b0;
    endcase
    if (I_HALT) begin
      tick = 1'b0;
    end
  end

  assign nxt_count = count_ff + 16'h0001;

  // free-running counter
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      count_ff <= `CNT_RESET;
    end else if (cnt_lo_wr) begin
      count_ff <= `CNT_RESET;
    end else if (tick) begin
      count_ff <= nxt_count;
    end
  end

  // control registers
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ctl1_ff <= 8'h00;
      ctl2_ff <= 8'h00;
    end else if (I_WR && I_ADDR == `FRT_CTL1) begin
      ctl1_ff <= I_WDATA;
    end else if (I_WR && I_ADDR == `FRT_CTL2) begin
      ctl2_ff <= I_WDATA;
    end
  end

  // overflow flag with two-step clear; set wins
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      overflow_flag_ff <= 1'b0;
      ovf_armed_ff     <= 1'b0;
    end else begin
      if (tick && count_ff == 16'hFFFF && !cnt_lo_wr) begin
        overflow_flag_ff <= 1'b1;
        ovf_armed_ff     <= 1'b0;
      end else if (ovf_armed_ff && (I_ADDR == `FRT_CNT_LO) && (I_RD || I_WR)) begin
        overflow_flag_ff <= 1'b0;
        ovf_armed_ff     <= 1'b0;
      end else if (st_rd && overflow_flag_ff) begin
        ovf_armed_ff <= 1'b1;
      end
    end
  end

  // two-byte counter read buffer, shared by main and alternate
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      low_buf_ff     <= 8'h00;
      low_buf_vld_ff <= 1'b0;
    end else if (I_RD && (I_ADDR == `FRT_CNT_HI || I_ADDR == `FRT_ACNT_HI)) begin
      if (!low_buf_vld_ff) begin
        low_buf_ff     <= count_ff[7:0];
        low_buf_vld_ff <= 1'b1;
      end
    end else if (I_RD && (I_ADDR == `FRT_CNT_LO || I_ADDR == `FRT_ACNT_LO)) begin
      low_buf_vld_ff <= 1'b0;
    end
  end

  // capture and compare channels
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_chan
      localparam reg_addr_t CAP_HI = (g == 0) ? `FRT_CAP1_HI : `FRT_CAP2_HI;
      localparam reg_addr_t CAP_LO = (g == 0) ? `FRT_CAP1_LO : `FRT_CAP2_LO;
      localparam reg_addr_t CMP_HI = (g == 0) ? `FRT_CMP1_HI : `FRT_CMP2_HI;
      localparam reg_addr_t CMP_LO = (g == 0) ? `FRT_CMP1_LO : `FRT_CMP2_LO;
      logic cap_fire;
      logic cap_lo_acc;
      logic cmp_lo_acc;
      logic lvl;
      logic out_en;

      assign cap_fire   = cap_edge[g] & cap_active[g] & ~cap_block_ff[g];
      assign cap_lo_acc = (I_ADDR == CAP_LO) && (I_RD || I_WR);
      assign cmp_lo_acc = (I_ADDR == CMP_LO) && (I_RD || I_WR);
      assign cmp_match[g] = tick && !cmp_hold_ff[g]
                            && (count_ff == compare_value_ff[g]);
      assign lvl    = (g == 0) ? ctl1_ff[`C1_LVL1] : ctl1_ff[`C1_LVL2];
      assign out_en = (g == 0) ? ctl2_ff[`C2_OUT1_EN] : ctl2_ff[`C2_OUT2_EN];

      always_ff @(posedge I_CLK) begin
        if (I_RST) begin
          capture_value_ff[g] <= 16'h0000;
          capture_flag_ff[g]  <= 1'b0;
          cap_armed_ff[g]     <= 1'b0;
          cap_block_ff[g]     <= 1'b0;
        end else begin
          if (cap_fire) begin
            capture_value_ff[g] <= count_ff;
          end
          if (I_RD && I_ADDR == CAP_HI) begin
            cap_block_ff[g] <= 1'b1;
          end else if (I_RD && I_ADDR == CAP_LO) begin
            cap_block_ff[g] <= 1'b0;
          end
          if (cap_fire) begin
            capture_flag_ff[g] <= 1'b1;
            cap_armed_ff[g]    <= 1'b0;
          end else if (cap_armed_ff[g] && cap_lo_acc) begin
            capture_flag_ff[g] <= 1'b0;
            cap_armed_ff[g]    <= 1'b0;
          end else if (st_rd && capture_flag_ff[g]) begin
            cap_armed_ff[g] <= 1'b1;
          end
        end
      end

      always_ff @(posedge I_CLK) begin
        if (I_RST) begin
          compare_value_ff[g] <= `CMP_RESET;
          cmp_hold_ff[g]      <= 1'b0;
        end else if (I_WR && I_ADDR == CMP_HI) begin
          compare_value_ff[g][15:8] <= I_WDATA;
          cmp_hold_ff[g]            <= 1'b1;
        end else if (I_WR && I_ADDR == CMP_LO) begin
          compare_value_ff[g][7:0] <= I_WDATA;
          cmp_hold_ff[g]           <= 1'b0;
        end
      end

      always_ff @(posedge I_CLK) begin
        if (I_RST) begin
          compare_flag_ff[g] <= 1'b0;
          cmp_armed_ff[g]    <= 1'b0;
          pin_ff[g]          <= 1'b0;
          oe_ff[g]           <= 1'b0;
        end else begin
          oe_ff[g] <= out_en;
          if (cmp_match[g] && out_en) begin
            pin_ff[g] <= lvl;
          end
          if (cmp_match[g]) begin
            compare_flag_ff[g] <= 1'b1;
            cmp_armed_ff[g]    <= 1'b0;
          end else if (cmp_armed_ff[g] && cmp_lo_acc) begin
            compare_flag_ff[g] <= 1'b0;
            cmp_armed_ff[g]    <= 1'b0;
          end else if (st_rd && compare_flag_ff[g]) begin
            cmp_armed_ff[g] <= 1'b1;
          end
        end
      end
    end
  endgenerate

  // interrupt requests, pending until enabled and unmasked
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      ovf_irq_ff <= 1'b0;
      cap_irq_ff <= 1'b0;
      cmp_irq_ff <= 1'b0;
    end else begin
      ovf_irq_ff <= overflow_flag_ff & ctl1_ff[`C1_OVF_IE] & I_CPU_UNMASK;
      cap_irq_ff <= (|capture_flag_ff) & ctl1_ff[`C1_CAP_IE] & I_CPU_UNMASK;
      cmp_irq_ff <= (|compare_flag_ff) & ctl1_ff[`C1_CMP_IE] & I_CPU_UNMASK;
    end
  end

  // read data, one cycle after the strobe
  always_ff @(posedge I_CLK) begin
    if (I_RST) begin
      rdata_ff <= 8'h00;
    end else if (I_RD) begin
      case (I_ADDR)
        `FRT_CTL1:    rdata_ff <= ctl1_ff;
        `FRT_CTL2:    rdata_ff <= ctl2_ff;
        `FRT_STATUS:  rdata_ff <= {capture_flag_ff[0], compare_flag_ff[0], overflow_flag_ff,
                                   capture_flag_ff[1], compare_flag_ff[1], 3'h0};
        `FRT_CAP1_HI: rdata_ff <= capture_value_ff[0][15:8];
        `FRT_CAP1_LO: rdata_ff <= capture_value_ff[0][7:0];
        `FRT_CMP1_HI: rdata_ff <= compare_value_ff[0][15:8];
        `FRT_CMP1_LO: rdata_ff <= compare_value_ff[0][7:0];
        `FRT_CAP2_HI: rdata_ff <= capture_value_ff[1][15:8];
        `FRT_CAP2_LO: rdata_ff <= capture_value_ff[1][7:0];
        `FRT_CMP2_HI: rdata_ff <= compare_value_ff[1][15:8];
        `FRT_CMP2_LO: rdata_ff <= compare_value_ff[1][7:0];
        `FRT_CNT_HI, `FRT_ACNT_HI: rdata_ff <= count_ff[15:8];
        `FRT_CNT_LO, `FRT_ACNT_LO: rdata_ff <= low_buf_vld_ff ? low_buf_ff
                                                              : count_ff[7:0];
        default:      rdata_ff <= 8'h00;
      endcase
    end
  end

  assign O_RDATA               = rdata_ff;
  assign O_COMPARE_OUTPUT_PIN1 = pin_ff[0];
  assign O_COMPARE_OUTPUT_PIN2 = pin_ff[1];
  assign O_COMPARE_OE1         = oe_ff[0];
  assign O_COMPARE_OE2         = oe_ff[1];
  assign O_OVF_IRQ             = ovf_irq_ff;
  assign O_CAP_IRQ             = cap_irq_ff;
  assign O_CMP_IRQ             = cmp_irq_ff;
endmodule : frt_timer
`default_nettype wire

// ---- verification/frt_timer_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
module frt_timer_chk (
  // clock and reset
  input wire logic               I_CLK,
  input wire logic               I_RST,
  // register port
  input wire frt_pkg::reg_addr_t I_ADDR,
  input wire frt_pkg::byte_t     I_WDATA,
  input wire logic               I_WR,
  input wire logic               I_RD,
  input wire logic [7:0]         O_RDATA,
  // pins and requests
  input wire logic               I_CPU_UNMASK,
  input wire logic               O_COMPARE_OUTPUT_PIN1,
  input wire logic               O_COMPARE_OE1,
  input wire logic               O_OVF_IRQ,
  input wire logic               O_CAP_IRQ,
  input wire logic               O_CMP_IRQ
);
  import frt_pkg::*;
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  property p_rdback;
    (I_WR && I_ADDR == 4'h5) ##1 (I_RD && I_ADDR == 4'h5) |=> O_RDATA == $past(I_WDATA, 2);
  endproperty
  a_ovf_masked: assert property (!I_CPU_UNMASK |=> !O_OVF_IRQ)
    else $error("overflow request while masked");
  a_cap_masked: assert property (!I_CPU_UNMASK |=> !O_CAP_IRQ)
    else $error("capture request while masked");
  a_cmp_masked: assert property (!I_CPU_UNMASK |=> !O_CMP_IRQ)
    else $error("compare request while masked");
  a_pin_reset: assert property ($past(I_RST) |-> !O_COMPARE_OUTPUT_PIN1 && !O_COMPARE_OE1)
    else $error("compare pin not low after reset");
  a_cnt_reload: assert property (
    (I_WR && (I_ADDR == 4'h8 || I_ADDR == 4'hA)) ##1 (I_RD && I_ADDR == 4'h7)
    |=> O_RDATA == 8'hFF) else $error("count not reloaded");
  a_ovf_clear: assert property (
    (I_RD && I_ADDR == 4'h2) ##1 (I_RD && I_ADDR == 4'h8 && O_RDATA[5]) ##2
    (I_RD && I_ADDR == 4'h2) |=> !O_RDATA[5]) else $error("overflow flag not cleared");
  a_alt_keeps: assert property (
    (I_RD && I_ADDR == 4'h2) ##1 (I_RD && I_ADDR == 4'hA && O_RDATA[5]) ##1 !(I_RD || I_WR)
    ##1 (I_RD && I_ADDR == 4'h2) |=> O_RDATA[5]) else $error("alternate read cleared flag");
  a_cmp_rdback: assert property (p_rdback)
    else $error("compare readback differs");
  c_ovf: cover property ($rose(O_OVF_IRQ));
  c_cap: cover property ($rose(O_CAP_IRQ));
  c_cmp: cover property ($rose(O_CMP_IRQ));
endmodule : frt_timer_chk
bind frt_timer frt_timer_chk i_chk (
  .I_CLK(I_CLK), .I_RST(I_RST), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA), .I_WR(I_WR),
  .I_RD(I_RD), .O_RDATA(O_RDATA), .I_CPU_UNMASK(I_CPU_UNMASK),
  .O_COMPARE_OUTPUT_PIN1(O_COMPARE_OUTPUT_PIN1), .O_COMPARE_OE1(O_COMPARE_OE1),
  .O_OVF_IRQ(O_OVF_IRQ), .O_CAP_IRQ(O_CAP_IRQ), .O_CMP_IRQ(O_CMP_IRQ)
);
`default_nettype wire

// ---- verification/frt_pin_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module frt_pin_model (
  // clock and requests
  input  wire logic       i_clk,
  input  wire logic [2:0] i_toggle,
  // pins
  output logic            o_ext_clk,
  output logic            o_cap_one,
  output logic            o_cap_two
);
  logic [2:0] gap = 3'h0;
  initial {o_ext_clk, o_cap_one, o_cap_two} = 3'h0;
  // each request flips one pin; ext clock refuses flips closer than five cycles
  always @(posedge i_clk) begin
    if (gap != 3'h0)
      gap <= gap - 3'h1;
    else if (i_toggle[0]) begin
      o_ext_clk <= !o_ext_clk;
      gap       <= 3'h4;
    end
    if (i_toggle[1])
      o_cap_one <= !o_cap_one;
    if (i_toggle[2])
      o_cap_two <= !o_cap_two;
  end
endmodule : frt_pin_model
`default_nettype wire

// ---- verification/frt_timer_bench.sv ----
`timescale 1ns/10ps
`default_nettype none
module frt_timer_bench;
  import frt_pkg::*;
  logic       clk = 1'b0, rst = 1'b1, wr = 1'b0, rd = 1'b0, unmask = 1'b0, halt = 1'b1;
  logic [2:0] tog = 3'h0;
  reg_addr_t  addr = 4'h0;
  byte_t      wdata = 8'h00;
  byte_t      rdout, rdata;
  logic       ext, cap1, cap2, pin1, pin2, oe1, oe2, ovf_irq, cap_irq, cmp_irq;
  int         fails = 0;
  int         compares = 0;
  always #25 clk = !clk;
  frt_pin_model i_pins (.i_clk(clk), .i_toggle(tog), .o_ext_clk(ext), .o_cap_one(cap1),
    .o_cap_two(cap2));
  frt_timer i_dut (
    .I_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd),
    .O_RDATA(rdout), .I_CPU_UNMASK(unmask), .I_HALT(halt), .I_EXT_CLOCK_PIN(ext),
    .I_CAPTURE_INPUT_ONE(cap1), .I_CAPTURE_INPUT_TWO(cap2), .O_COMPARE_OUTPUT_PIN1(pin1),
    .O_COMPARE_OUTPUT_PIN2(pin2), .O_COMPARE_OE1(oe1), .O_COMPARE_OE2(oe2),
    .O_OVF_IRQ(ovf_irq), .O_CAP_IRQ(cap_irq), .O_CMP_IRQ(cmp_irq)
  );
  task automatic chk(input string n, input byte_t s, input byte_t e);
    compares++;
    if (s !== e) begin
      fails++;
      $display("mismatch %s exp %h seen %h", n, e, s);
    end
  endtask : chk
  task automatic bus(input logic w, input reg_addr_t a, input byte_t d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk) #1 rdata = rdout;
  endtask : bus
  task automatic rdc(input string n, input reg_addr_t a, input byte_t e);
    bus(1'b0, a, 8'h00);
    chk(n, rdata, e);
  endtask : rdc
  task automatic cyc(input int n);
    repeat (n) begin
      wr <= 1'b0;
      rd <= 1'b0;
      @(posedge clk) #1;
    end
  endtask : cyc
  task automatic pin(input logic [2:0] t);
    tog <= t;
    cyc(1);
    tog <= 3'h0;
  endtask : pin
  task automatic run(input int n);
    halt <= 1'b0;
    cyc(n);
    halt <= 1'b1;
  endtask : run
  task automatic t_reset;
    rdc("cmp1 hi", 4'h5, 8'h80);
    rdc("cmp2 lo", 4'hE, 8'h00);
    rdc("cnt hi", 4'h7, 8'hFF);
    rdc("cnt lo", 4'h8, 8'hFC);
  endtask : t_reset
  task automatic t_pair;
    rdc("pair hi", 4'h7, 8'hFF);
    run(8);
    rdc("again hi", 4'h7, 8'hFF);
    rdc("buffered lo", 4'h8, 8'hFC);
    rdc("live lo", 4'h8, 8'hFE);
    cyc(4);
    rdc("held hi", 4'h9, 8'hFF);
    rdc("held lo", 4'hA, 8'hFE);
    bus(1'b1, 4'h8, 8'h00);
    rdc("reload hi", 4'h7, 8'hFF);
    rdc("reload lo", 4'h8, 8'hFC);
  endtask : t_pair
  task automatic t_ovf;
    bus(1'b1, 4'h0, 8'h20);
    bus(1'b1, 4'h1, 8'h04);
    bus(1'b1, 4'h8, 8'h00);
    run(12);
    chk("ovf irq masked", {7'h0, ovf_irq}, 8'h00);
    unmask <= 1'b1;
    cyc(2);
    chk("ovf irq", {7'h0, ovf_irq}, 8'h01);
    rdc("status ovf", 4'h2, 8'h20);
    bus(1'b0, 4'hA, 8'h00);
    cyc(1);
    rdc("status kept", 4'h2, 8'h20);
    bus(1'b0, 4'h8, 8'h00);
    cyc(1);
    rdc("status clr", 4'h2, 8'h00);
    chk("ovf irq clr", {7'h0, ovf_irq}, 8'h00);
  endtask : t_ovf
  task automatic t_cap;
    bus(1'b1, 4'h0, 8'h82);
    rdc("frozen hi", 4'h7, 8'h00);
    rdc("frozen lo", 4'h8, 8'h02);
    pin(3'h2);
    cyc(6);
    chk("cap irq", {7'h0, cap_irq}, 8'h01);
    unmask <= 1'b0;
    cyc(2);
    chk("cap irq masked", {7'h0, cap_irq}, 8'h00);
    unmask <= 1'b1;
    rdc("status cap1", 4'h2, 8'h80);
    rdc("cap1 hi", 4'h3, 8'h00);
    run(10);
    pin(3'h2);
    cyc(3);
    pin(3'h2);
    cyc(6);
    rdc("cap1 lo blocked", 4'h4, 8'h02);
    rdc("status blocked", 4'h2, 8'h00);
    rdc("count hi", 4'h7, 8'h00);
    rdc("count lo", 4'h8, 8'h07);
    pin(3'h2);
    cyc(3);
    pin(3'h2);
    cyc(6);
    rdc("cap1 hi new", 4'h3, 8'h00);
    rdc("cap1 lo new", 4'h4, 8'h07);
    pin(3'h4);
    cyc(6);
    rdc("cap2 rise ignored", 4'h2, 8'h80);
    pin(3'h4);
    cyc(6);
    rdc("cap2 fall", 4'h2, 8'h90);
    bus(1'b0, 4'h4, 8'h00);
    bus(1'b0, 4'hC, 8'h00);
    bus(1'b1, 4'h1, 8'h24);
    pin(3'h6);
    cyc(3);
    pin(3'h6);
    cyc(6);
    rdc("pulse mode cap", 4'h2, 8'h10);
    bus(1'b0, 4'hC, 8'h00);
  endtask : t_cap
  task automatic t_cmp;
    bus(1'b1, 4'h5, 8'hFF);
    rdc("cmp1 hi rw", 4'h5, 8'hFF);
    bus(1'b1, 4'h6, 8'hFE);
    bus(1'b1, 4'hE, 8'hFE);
    bus(1'b1, 4'hD, 8'hFF);
    bus(1'b1, 4'h0, 8'h41);
    bus(1'b1, 4'h1, 8'h84);
    bus(1'b1, 4'h8, 8'h00);
    run(10);
    cyc(2);
    chk("cmp pin", {6'h0, oe1, pin1}, 8'h03);
    chk("cmp irq", {7'h0, cmp_irq}, 8'h01);
    unmask <= 1'b0;
    cyc(2);
    chk("cmp irq masked", {7'h0, cmp_irq}, 8'h00);
    unmask <= 1'b1;
    rdc("status cmp1", 4'h2, 8'h60);
    bus(1'b1, 4'hE, 8'hFE);
    bus(1'b1, 4'h0, 8'h45);
    bus(1'b1, 4'h1, 8'hC4);
    bus(1'b1, 4'h8, 8'h00);
    run(10);
    rdc("status cmp2", 4'h2, 8'h68);
    chk("cmp pin2", {6'h0, oe2, pin2}, 8'h03);
  endtask : t_cmp
  task automatic t_ext;
    bus(1'b1, 4'h1, 8'h0D);
    bus(1'b1, 4'h8, 8'h00);
    halt <= 1'b0;
    repeat (3) begin
      pin(3'h1);
      cyc(6);
      pin(3'h1);
      cyc(6);
    end
    rdc("ext count lo", 4'h8, 8'hFF);
  endtask : t_ext
  task automatic stop_test;
    if (fails == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : stop_test
  initial begin
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    #1;
    t_reset();
    t_pair();
    t_ovf();
    t_cap();
    t_cmp();
    t_ext();
    stop_test();
  end
  initial begin
    #100000;
    fails++;
    stop_test();
  end
endmodule : frt_timer_bench
`default_nettype wire
